// *** verilog/cev_pkg.sv ***
// Constants for the comparator event control block.
// Assumes a single 100 MHz clock and an APB register bus.
// Functional notes
// R1 - Result bit is high while positive input exceeds negative input, else low.
// R2 - Result bit 5 is read-only and follows the comparator output unlatched.
// R3 - Comparator owns a private interrupt source driven by output events.
// R4 - Power-off bit 7 switches comparator power off; writable any time.
// R5 - Software clears irq enable before changing power-off bit.
// R6 - Bit 6 is reserved and always reads zero.
// R7 - Event flag bit 4 sets on an output transition matching edge-select mode.
// R8 - Interrupt is taken only with flag, local enable and global enable all set.
// R9 - Executing the comparator vector clears the event flag in hardware.
// R10 - Writing one to the event flag clears it; writing zero keeps it.
// R11 - Irq enable bit 3 activates interrupt with global enable; clear disables.
// R12 - Capture-route bit 2 feeds output into timer capture trigger, else none.
// R13 - Routed output passes the capture noise canceler and edge selection.
// R14 - Comparator capture raises timer capture irq only when its mask is set.
// R15 - Edge select bits 1,0: 00 toggle, 01 reserved, 10 falling, 11 rising.
// R16 - Software clears irq enable before changing edge-select field.
// R17 - Output is synchronised; edges found against previous sampled value.
package cev_pkg;
    localparam logic [11:0] CEV_CSR_ADDR = 12'h008;
    localparam logic [11:0] CEV_IST_ADDR = 12'h00C;
    localparam logic [11:0] CEV_IMK_ADDR = 12'h010;
    localparam int CEV_BIT_PWR_OFF = 7;
    localparam int CEV_BIT_RSVD = 6;
    localparam int CEV_BIT_RESULT = 5;
    localparam int CEV_BIT_FLAG = 4;
    localparam int CEV_BIT_IE = 3;
    localparam int CEV_BIT_ROUTE = 2;
    localparam int CEV_BIT_SEL_HI = 1;
    localparam int CEV_BIT_SEL_LO = 0;
    localparam logic [7:0] CEV_CSR_RESET = 8'h00;
    localparam logic [1:0] CEV_SEL_TOGGLE = 2'h0;
    localparam logic [1:0] CEV_SEL_RSVD = 2'h1;
    localparam logic [1:0] CEV_SEL_FALL = 2'h2;
    localparam logic [1:0] CEV_SEL_RISE = 2'h3;
    // Status/mask bits for the system interrupt line
    localparam int CEV_IST_EVENT = 0;
    localparam int CEV_IST_CAPTURE = 1;
    localparam int CEV_IST_W = 2;
    // Noise canceler needs this many equal samples in a row
    localparam int CEV_NC_LEN = 4;
    localparam logic [2:0] CEV_NC_CNT_MAX = 3'h3;
endpackage : cev_pkg

// *** verilog/cev_evt_if.sv ***
// Carries comparator level and capture front-end signals between modules.
// Assumes one clock domain; all members are synchronous levels or pulses.
`timescale 1ns/1ps
`default_nettype none
interface cev_evt_if;
    logic level;
    logic noise_cancel_en;
    logic capture_rising;
    logic capture_pulse;
    modport src (output level, input noise_cancel_en, input capture_rising,
        input capture_pulse);
    modport cap (input level, input noise_cancel_en, input capture_rising,
        output capture_pulse);
endinterface : cev_evt_if
`default_nettype wire

// *** verilog/cev_capture_front.sv ***
// Timer capture front end: optional noise canceler and edge select.
// Assumes the input level is already synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module cev_capture_front
    import cev_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    cev_evt_if.cap evt
);
    typedef struct packed {
        logic [2:0] cnt;
        logic filt;
        logic prev;
        logic pulse;
    } cev_cap_state_t;
    cev_cap_state_t st_r;
    cev_cap_state_t st_nxt;
    logic lvl;

    always_comb
    begin
        st_nxt = st_r;
        // R13: level must hold several samples before the filtered copy follows
        if (evt.level == st_r.filt)
        begin
            st_nxt.cnt = 3'h0;
        end
        else if (st_r.cnt == CEV_NC_CNT_MAX)
        begin
            st_nxt.cnt = 3'h0;
            st_nxt.filt = evt.level;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + 3'h1;
        end
        lvl = evt.noise_cancel_en ? st_r.filt : evt.level; // R13
        st_nxt.prev = lvl;
        st_nxt.pulse = evt.capture_rising ? (lvl & ~st_r.prev)
                                          : (~lvl & st_r.prev); // R13
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign evt.capture_pulse = st_r.pulse;
endmodule : cev_capture_front
`default_nettype wire

// *** verilog/cev_top.sv ***
// Comparator event control: APB register, edge detection, interrupt gating,
// capture routing and power control around an analog comparator.
// Assumes comparator output arrives as a level synchronous to nothing in
// particular; it is synchronised here. The timer capture front end is instantiated here; the timer itself lives outside.
`timescale 1ns/1ps
`default_nettype none
module cev_top
    import cev_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comparator_out,
    input wire logic global_irq_enable,
    input wire logic vector_ack,
    input wire logic capture_noise_cancel,
    input wire logic capture_edge_rising,
    input wire logic timer_capture_irq_mask,
    output logic comparator_power_off,
    output logic comparator_irq,
    output logic capture_trigger,
    output logic timer_capture_irq,
    output logic irq
);
    typedef enum logic [1:0] {
        CEV_ST_IDLE = 2'b00,
        CEV_ST_ARMED = 2'b01,
        CEV_ST_HOLD = 2'b11
    } cev_phase_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic power_off;
        logic flag;
        logic irq_en;
        logic route;
        logic [1:0] sel;
        logic [CEV_IST_W-1:0] ist;
        logic [CEV_IST_W-1:0] imk;
        logic [31:0] rdata;
        cev_phase_t phase;
    } cev_state_t;

    cev_state_t st_r;
    cev_state_t st_nxt;
    // Kept apart from the state struct: its two flops are the only ones reset by the raw reset
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic rise;
    logic fall;
    logic hit;
    logic wr_csr;
    logic rd_ist;
    logic [7:0] csr_view;
    logic cap_pulse;
    logic [CEV_IST_W-1:0] ev_vec;
    cev_evt_if evt ();

    // Reset release through two flops; the rest of the design uses rst_n
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_sync_r <= 2'h0;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Comparator powered down gives a stable low, so no phantom edges follow
    assign evt.level = st_r.sync2 & ~st_r.power_off & st_r.route; // R12
    assign evt.noise_cancel_en = capture_noise_cancel;
    assign evt.capture_rising = capture_edge_rising;
    assign cap_pulse = evt.capture_pulse;

    cev_capture_front u_capture (
        .mclk(mclk),
        .rst_n(rst_n),
        .evt(evt)
    );

    always_comb
    begin
        rise = st_r.sync2 & ~st_r.prev; // R17
        fall = ~st_r.sync2 & st_r.prev; // R17
        case (st_r.sel) // R15
            CEV_SEL_TOGGLE: hit = rise | fall;
            CEV_SEL_FALL: hit = fall;
            CEV_SEL_RISE: hit = rise;
            default: hit = 1'b0;
        endcase
        csr_view = 8'h00;
        csr_view[CEV_BIT_PWR_OFF] = st_r.power_off;
        csr_view[CEV_BIT_RSVD] = 1'b0; // R6
        csr_view[CEV_BIT_RESULT] = st_r.sync2; // R2
        csr_view[CEV_BIT_FLAG] = st_r.flag;
        csr_view[CEV_BIT_IE] = st_r.irq_en;
        csr_view[CEV_BIT_ROUTE] = st_r.route;
        csr_view[CEV_BIT_SEL_HI] = st_r.sel[1];
        csr_view[CEV_BIT_SEL_LO] = st_r.sel[0];
        wr_csr = psel & penable & pwrite & pstrb[0] & (paddr == CEV_CSR_ADDR);
        rd_ist = psel & penable & ~pwrite & (paddr == CEV_IST_ADDR);
        ev_vec = '0;
        ev_vec[CEV_IST_EVENT] = hit;
        ev_vec[CEV_IST_CAPTURE] = cap_pulse;
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sync1 = comparator_out; // R1
        st_nxt.sync2 = st_r.sync1; // R17
        st_nxt.prev = st_r.sync2; // R17
        // Setup/access phase tracker; zero wait states
        case (st_r.phase)
            CEV_ST_IDLE: st_nxt.phase = psel ? CEV_ST_ARMED : CEV_ST_IDLE;
            CEV_ST_ARMED: st_nxt.phase = penable ? CEV_ST_HOLD : CEV_ST_ARMED;
            CEV_ST_HOLD: st_nxt.phase = psel ? CEV_ST_ARMED : CEV_ST_IDLE;
            default: st_nxt.phase = CEV_ST_IDLE;
        endcase
        if (wr_csr)
        begin
            st_nxt.power_off = pwdata[CEV_BIT_PWR_OFF]; // R4
            st_nxt.irq_en = pwdata[CEV_BIT_IE]; // R11
            st_nxt.route = pwdata[CEV_BIT_ROUTE]; // R12
            st_nxt.sel = pwdata[CEV_BIT_SEL_HI:CEV_BIT_SEL_LO]; // R15
        end
        if (psel & penable & pwrite & pstrb[0] & (paddr == CEV_IMK_ADDR))
        begin
            st_nxt.imk = pwdata[CEV_IST_W-1:0];
        end
        // Clears first, so a same-cycle event still sets the flag
        if (wr_csr && pwdata[CEV_BIT_FLAG])
        begin
            st_nxt.flag = 1'b0; // R10
        end
        if (vector_ack)
        begin
            st_nxt.flag = 1'b0; // R9
        end
        if (hit)
        begin
            st_nxt.flag = 1'b1; // R7
        end
        // Only bits handed out in the setup cycle are cleared, so an event
        // landing between setup and access is kept for the next read
        if (rd_ist)
        begin
            st_nxt.ist = st_r.ist & ~st_r.rdata[CEV_IST_W-1:0];
        end
        st_nxt.ist = st_nxt.ist | ev_vec;
        if (psel & ~penable & ~pwrite)
        begin
            case (paddr)
                CEV_CSR_ADDR: st_nxt.rdata = {24'h000000, csr_view};
                CEV_IST_ADDR: st_nxt.rdata = {30'h0, st_r.ist};
                CEV_IMK_ADDR: st_nxt.rdata = {30'h0, st_r.imk};
                default: st_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r.sync1 <= 1'b0;
            st_r.sync2 <= 1'b0;
            st_r.prev <= 1'b0;
            st_r.power_off <= CEV_CSR_RESET[CEV_BIT_PWR_OFF];
            st_r.flag <= CEV_CSR_RESET[CEV_BIT_FLAG];
            st_r.irq_en <= CEV_CSR_RESET[CEV_BIT_IE];
            st_r.route <= CEV_CSR_RESET[CEV_BIT_ROUTE];
            st_r.sel <= CEV_CSR_RESET[CEV_BIT_SEL_HI:CEV_BIT_SEL_LO];
            st_r.ist <= '0;
            st_r.imk <= '0;
            st_r.rdata <= 32'h00000000;
            st_r.phase <= CEV_ST_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.rdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign comparator_power_off = st_r.power_off; // R4
    // R3, R8, R11: private comparator interrupt line
    assign comparator_irq = st_r.flag & st_r.irq_en & global_irq_enable;
    assign capture_trigger = cap_pulse; // R12
    assign timer_capture_irq = cap_pulse & timer_capture_irq_mask; // R14
    assign irq = |(st_r.ist & st_r.imk);

    a_irq_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        comparator_irq == (st_r.flag & st_r.irq_en & global_irq_enable))
        else $error("comparator irq gating wrong"); // R8
    a_rise_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r.sel == CEV_SEL_RISE && rise) |=> st_r.flag)
        else $error("rising edge did not set flag"); // R7
    a_fall_only: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r.sel == CEV_SEL_FALL && rise && !st_r.flag) |-> !hit)
        else $error("rise triggered in falling mode"); // R15
    a_rsvd_mode: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r.sel == CEV_SEL_RSVD) |-> !hit)
        else $error("reserved mode produced event"); // R15
    a_result_lag: assert property (@(posedge mclk) disable iff (!rst_n)
        csr_view[CEV_BIT_RESULT] == $past(comparator_out, 2))
        else $error("result bit not following comparator"); // R2
    a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r.phase == CEV_ST_HOLD && $past(paddr) == CEV_CSR_ADDR)
        |-> prdata[CEV_BIT_RSVD] == 1'b0)
        else $error("reserved bit read nonzero"); // R6
    a_w1c_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_csr && pwdata[CEV_BIT_FLAG] && !hit) |=> !st_r.flag)
        else $error("write one did not clear flag"); // R10
    a_w0_keep: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_csr && !pwdata[CEV_BIT_FLAG] && !vector_ack && st_r.flag) |=> st_r.flag)
        else $error("write zero cleared flag"); // R10
    a_vec_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (vector_ack && !hit) |=> !st_r.flag)
        else $error("vector did not clear flag"); // R9
    a_no_route: assert property (@(posedge mclk) disable iff (!rst_n)
        (!st_r.route) [*8] |-> !capture_trigger)
        else $error("capture trigger without route"); // R12
    a_cap_mask: assert property (@(posedge mclk) disable iff (!rst_n)
        timer_capture_irq |-> timer_capture_irq_mask && capture_trigger)
        else $error("capture irq without mask"); // R14
    a_pwr_out: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(st_r.power_off) |-> $past(wr_csr))
        else $error("power off changed without write"); // R4
    a_fall_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r.sel == CEV_SEL_FALL && fall) |=> st_r.flag)
        else $error("falling edge did not set flag"); // R7
    a_toggle_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_r.sel == CEV_SEL_TOGGLE && (rise || fall)) |=> st_r.flag)
        else $error("toggle did not set flag"); // R15
    a_no_event: assert property (@(posedge mclk) disable iff (!rst_n)
        (!hit && !st_r.flag) |=> !st_r.flag)
        else $error("flag set without event"); // R7
    a_pwr_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_csr |=> comparator_power_off == $past(pwdata[CEV_BIT_PWR_OFF]))
        else $error("power off bit not stored"); // R4
    a_ie_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_csr |=> st_r.irq_en == $past(pwdata[CEV_BIT_IE]))
        else $error("irq enable bit not stored"); // R11
    a_route_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_csr |=> st_r.route == $past(pwdata[CEV_BIT_ROUTE]))
        else $error("route bit not stored"); // R12
    a_route_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        !st_r.route |-> !evt.level)
        else $error("capture level passed without route"); // R12
    a_ist_event: assert property (@(posedge mclk) disable iff (!rst_n)
        hit |=> st_r.ist[CEV_IST_EVENT])
        else $error("event not recorded in status"); // R3
    c_fall_mode: cover property (@(posedge mclk) disable iff (!rst_n)
        st_r.sel == CEV_SEL_FALL && hit);
    c_vec_clear: cover property (@(posedge mclk) disable iff (!rst_n)
        vector_ack && st_r.flag);
    c_toggle_irq: cover property (@(posedge mclk) disable iff (!rst_n)
        st_r.sel == CEV_SEL_TOGGLE && hit ##1 comparator_irq);
    c_capture: cover property (@(posedge mclk) disable iff (!rst_n)
        timer_capture_irq);
    c_set_wins: cover property (@(posedge mclk) disable iff (!rst_n)
        wr_csr && pwdata[CEV_BIT_FLAG] && hit);
endmodule : cev_top
`default_nettype wire

// *** dv/cev_cmp_model.sv ***
// Behavioural analog comparator feeding the block's comparator input.
// Assumes the bench gives both input voltages as unsigned codes.
`timescale 1ns/1ps
`default_nettype none
module cev_cmp_model
(
    input wire logic [7:0] vpos,
    input wire logic [7:0] vneg,
    output logic level
);
    // Equal inputs give low, so only a strict excess sets the output
    assign level = (vpos > vneg);
endmodule : cev_cmp_model
`default_nettype wire

// *** dv/comparator_event_control_bench.sv ***
// Self-checking bench for cev_top with a comparator model on its input.
// Assumes the APB slave answers with pready; every wait is bounded.
`timescale 1ns/1ps
`default_nettype none
module comparator_event_control_bench
    import cev_pkg::*;
;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr;
    logic ge, vack, nc, erise, tmask, cpo, cirq, ctrig, tcirq, irq, cmp_o;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] vpos, vneg;
    int failures, cmp_count, tc, ti;
    logic [31:0] er [4] = '{32'h10, 32'h00, 32'h00, 32'h10};
    logic [31:0] ef [4] = '{32'h10, 32'h00, 32'h10, 32'h00};

    cev_cmp_model cmp0 (.vpos(vpos), .vneg(vneg), .level(cmp_o));
    cev_top uut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .comparator_out(cmp_o),
        .global_irq_enable(ge), .vector_ack(vack), .capture_noise_cancel(nc),
        .capture_edge_rising(erise), .timer_capture_irq_mask(tmask),
        .comparator_power_off(cpo), .comparator_irq(cirq), .capture_trigger(ctrig),
        .timer_capture_irq(tcirq), .irq(irq));

    always #5 mclk = ~mclk;

    task end_sim;
        $display("failures=%0d compares=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            failures++;
            end_sim();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Moves the comparator to level b, back again hold+1 cycles later if hold is below 14, and
    // counts capture pulses over a window long enough for the canceler.
    task run(input logic b, input int hold);
        int i;
        tc = 0;
        ti = 0;
        @(posedge mclk);
        vpos <= b ? 8'hC0 : 8'h40;
        for (i = 0; i < 14; i++)
        begin
            @(posedge mclk);
            if (i == hold)
                vpos <= b ? 8'h40 : 8'hC0;
            tc += (ctrig === 1'b1);
            ti += (tcirq === 1'b1);
        end
    endtask : run

    task t_reset;
        apb(1'b0, CEV_CSR_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h004, 32'hFF);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        $display("done reset");
    endtask : t_reset

    task t_bits;
        run(1'b1, 99);
        apb(1'b1, CEV_CSR_ADDR, 32'h40);
        apb(1'b0, CEV_CSR_ADDR, 32'h0);
        chk(rd, 32'h30);
        run(1'b0, 99);
        apb(1'b1, CEV_CSR_ADDR, 32'h10);
        apb(1'b0, CEV_CSR_ADDR, 32'h0);
        chk(rd, 32'h0);
        $display("done bits");
    endtask : t_bits

    task t_modes;
        int m;
        for (m = 0; m < 4; m++)
        begin
            // Interrupt enable stays clear while the mode changes
            apb(1'b1, CEV_CSR_ADDR, 32'h10 | m);
            run(1'b1, 99);
            apb(1'b0, CEV_CSR_ADDR, 32'h0);
            chk(rd & 32'h10, er[m]);
            apb(1'b1, CEV_CSR_ADDR, 32'h10 | m);
            run(1'b0, 99);
            apb(1'b0, CEV_CSR_ADDR, 32'h0);
            chk(rd & 32'h10, ef[m]);
        end
        $display("done modes");
    endtask : t_modes

    task t_irq;
        apb(1'b1, CEV_CSR_ADDR, 32'h10);
        apb(1'b1, CEV_CSR_ADDR, 32'h08);
        run(1'b1, 99);
        @(negedge mclk);
        chk(32'(cirq), 32'h0);
        @(posedge mclk);
        ge <= 1'b1;
        @(negedge mclk);
        chk(32'(cirq), 32'h1);
        apb(1'b1, CEV_CSR_ADDR, 32'h00);
        @(negedge mclk);
        chk(32'(cirq), 32'h0);
        apb(1'b1, CEV_CSR_ADDR, 32'h08);
        @(negedge mclk);
        chk(32'(cirq), 32'h1);
        @(posedge mclk);
        vack <= 1'b1;
        @(posedge mclk);
        vack <= 1'b0;
        @(negedge mclk);
        chk(32'(cirq), 32'h0);
        @(posedge mclk);
        ge <= 1'b0;
        apb(1'b1, CEV_CSR_ADDR, 32'h00);
        $display("done irq");
    endtask : t_irq

    task t_power;
        apb(1'b1, CEV_CSR_ADDR, 32'h80);
        @(negedge mclk);
        chk(32'(cpo), 32'h1);
        apb(1'b0, CEV_CSR_ADDR, 32'h0);
        chk(rd & 32'hC0, 32'h80);
        apb(1'b1, CEV_CSR_ADDR, 32'h00);
        @(negedge mclk);
        chk(32'(cpo), 32'h0);
        $display("done power");
    endtask : t_power

    task t_capture;
        run(1'b0, 99);
        apb(1'b1, CEV_CSR_ADDR, 32'h04);
        run(1'b1, 99);
        chk(32'(tc), 32'h1);
        chk(32'(ti), 32'h0);
        run(1'b0, 99);
        chk(32'(tc), 32'h0);
        tmask <= 1'b1;
        run(1'b1, 99);
        chk(32'(ti), 32'h1);
        run(1'b0, 99);
        nc <= 1'b1;
        run(1'b1, 2);
        chk(32'(tc), 32'h0);
        run(1'b1, 99);
        chk(32'(tc), 32'h1);
        erise <= 1'b0;
        run(1'b0, 99);
        chk(32'(tc), 32'h1);
        erise <= 1'b1;
        apb(1'b1, CEV_CSR_ADDR, 32'h00);
        run(1'b0, 99);
        run(1'b1, 99);
        chk(32'(tc), 32'h0);
        $display("done capture");
    endtask : t_capture

    task t_status;
        apb(1'b0, CEV_IST_ADDR, 32'h0);
        apb(1'b1, CEV_IMK_ADDR, 32'h1);
        apb(1'b1, CEV_CSR_ADDR, 32'h10);
        run(1'b0, 99);
        @(negedge mclk);
        chk(32'(irq), 32'h1);
        apb(1'b0, CEV_IST_ADDR, 32'h0);
        chk(rd & 32'h1, 32'h1);
        @(negedge mclk);
        chk(32'(irq), 32'h0);
        apb(1'b1, CEV_IMK_ADDR, 32'h0);
        run(1'b1, 99);
        @(negedge mclk);
        chk(32'(irq), 32'h0);
        $display("done status");
    endtask : t_status

    initial
    begin
        mclk = 1'b0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        {ge, vack, nc, tmask} = 4'h0;
        erise = 1'b1;
        vpos = 8'h40;
        vneg = 8'h80;
        failures = 0;
        cmp_count = 0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset;
        t_bits;
        t_modes;
        t_irq;
        t_power;
        t_capture;
        t_status;
        end_sim;
    end
endmodule : comparator_event_control_bench
`default_nettype wire
